/* File: src/supply_switchover_mode_sequencer.v */
// supply switchover and power mode sequencer, always-on domain
// assumes comparator and pin inputs already synchronous to clk_i
// delay counts default to the full-length figures; a bench may shorten them
`timescale 1ns/100ps
`default_nettype none
`include "supply_seq_consts.vh"
module supply_switchover_mode_sequencer #(
    parameter [31:0] DC_SWITCH_CYC = `T_DC_SWITCH_CYC,
    parameter [31:0] RESTORE_CYC = `T_RESTORE_CYC
) (
    input wire clk_i,
    input wire rstn_i,
    input wire dc_sense_low_i,
    input wire main_low_i,
    input wire external_switchover_pin_i,
    input wire wake_event_i,
    input wire sleep_req_i,
    input wire [7:0] temp_result_i,
    input wire [7:0] backup_result_i,
    input wire [7:0] dc_result_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    output reg rail_source_status_o,
    output reg switchover_warning_flag_o,
    output reg internal_analog_rail_en_o,
    output reg internal_logic_rail_en_o,
    output reg ram_valid_o,
    output reg core_restart_o,
    output reg [2:0] core_clk_div_o,
    output reg [3:0] aon_peripheral_config_en_o,
    output reg [1:0] mode_o
);

    localparam [31:0] MIN_CYC = `T_MIN_CYC;
    localparam [1:0] NORMAL = `MODE_NORMAL;
    localparam [1:0] BACKUP = `MODE_BACKUP;
    localparam [1:0] SLEEP = `MODE_SLEEP;

    // addresses that hold a register
    function is_mapped;
        input [7:0] a;
        begin
            case (a)
                // core-side mode control, lost in deep sleep
                `A_METERING_MODE_CONTROL_ONE,
                // lcd configuration and display memory
                `A_LCD_MAIN,
                `A_LCD_CLK,
                `A_LCD_SEG_A,
                `A_LCD_X,
                `A_LCD_PTR,
                `A_LCD_DATA,
                `A_LCD_Y,
                `A_LCD_SEG_B,
                // clock and calendar, with its trims
                `A_RTC_CFG,
                `A_RTC_H100,
                `A_RTC_S,
                `A_RTC_M,
                `A_RTC_H,
                `A_RTC_ALARM,
                `A_RTC_TRIM,
                `A_TEMP_TRIM,
                // pin configuration
                `A_PULL0,
                `A_PULL1,
                `A_PULL2,
                `A_INT_PIN,
                // supply monitoring and converter results
                `A_TEMP_RES,
                `A_BAT_RES,
                `A_DC_RES,
                `A_DELTA_CFG,
                `A_PERIPHERAL_CONFIG,
                `A_SWO_CFG,
                `A_EVT_FLAGS,
                `A_STRB_PER,
                `A_BAT_TH:
                    is_mapped = 1'b1;
                // the four retained stores form one contiguous range
                default:
                    is_mapped = (a >= `A_STORE1) && (a <= `A_STORE4);
            endcase
        end
    endfunction

    // plain storage registers, excluding converter results and flags
    function is_store;
        input [7:0] a;
        begin
            case (a)
                `A_TEMP_RES, `A_BAT_RES, `A_DC_RES, `A_EVT_FLAGS:
                    is_store = 1'b0;
                default:
                    is_store = is_mapped(a);
            endcase
        end
    endfunction

    // saturating delay counter step
    function [31:0] count_step;
        input cond;
        input [31:0] cnt;
        begin
            if (!cond)
                count_step = 32'h0000_0000;
            else if (cnt == 32'hffff_ffff)
                count_step = cnt;
            else
                count_step = cnt + 32'h0000_0001;
        end
    endfunction

    // register file lives on the always-on rail, so it survives sleep except the mode control register
    reg [7:0] rf [0:255];
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [31:0] dc_cnt_reg;
    reg [31:0] main_cnt_reg;
    reg [31:0] rest_cnt_reg;
    reg pin_prev_reg;
    reg flag_sw_reg;
    reg flag_rest_reg;
    reg set_sw;
    reg set_rest;
    reg restart_next;
    reg [7:0] rdata_next;
    integer i;

    wire [1:0] sel = rf[`A_SWO_CFG][1:0];
    wire [1:0] pin_cfg = rf[`A_INT_PIN][3:2];
    wire pin_en = (pin_cfg == `PIN_EN_CODE);
    wire pin_fall = pin_en && pin_prev_reg && !external_switchover_pin_i;
    wire dc_used = (sel == `SEL_DC_AND_MAIN);
    wire metering_powerdown_bit = rf[`A_METERING_MODE_CONTROL_ONE][`B_METERING_POWERDOWN_BIT];
    wire core_on = (mode_reg != SLEEP);
    wire wr_ok = sfr_wr_i && core_on;

    // restore needs main ok, dc ok when used, pin high when enabled, metering powerdown bit clear
    wire restore_cond = !main_low_i && !(dc_used && dc_sense_low_i)
        && !(pin_en && !external_switchover_pin_i) && !metering_powerdown_bit;

    // switchover triggers while running from main
    wire main_trip = (main_cnt_reg >= MIN_CYC);
    wire dc_trip = dc_used && (dc_cnt_reg >= DC_SWITCH_CYC);
    wire to_backup = main_trip || dc_trip || pin_fall;
    // condition must still hold on the expiring cycle, so a late dip restarts the wait
    wire restore_done = restore_cond && (rest_cnt_reg >= RESTORE_CYC);

    // mode sequencing
    always @*
    begin
        mode_next = mode_reg;
        set_sw = 1'b0;
        set_rest = 1'b0;
        restart_next = 1'b0;
        case (mode_reg)
            NORMAL:
            begin
                if (to_backup || sleep_req_i)
                begin
                    mode_next = to_backup ? BACKUP : SLEEP;
                    set_sw = 1'b1;
                end
            end
            BACKUP:
            begin
                if (restore_done)
                begin
                    mode_next = NORMAL;
                    set_rest = 1'b1;
                end
                else if (sleep_req_i)
                    mode_next = SLEEP;
            end
            SLEEP:
            begin
                if (restore_done)
                begin
                    mode_next = NORMAL;
                    set_rest = 1'b1;
                    restart_next = 1'b1;
                end
                else if (wake_event_i)
                begin
                    mode_next = BACKUP;
                    restart_next = 1'b1;
                end
            end
            default:
                mode_next = NORMAL;
        endcase
    end

    // read data; bit 6 of peripheral config is the live rail source
    always @*
    begin
        rdata_next = 8'h00;
        case (sfr_addr_i)
            `A_TEMP_RES: rdata_next = temp_result_i;
            `A_BAT_RES: rdata_next = backup_result_i;
            `A_DC_RES: rdata_next = dc_result_i;
            `A_EVT_FLAGS:
            begin
                rdata_next[`B_RESTORED] = flag_rest_reg;
                rdata_next[`B_SWITCHED] = flag_sw_reg;
            end
            `A_PERIPHERAL_CONFIG:
            begin
                rdata_next = rf[`A_PERIPHERAL_CONFIG];
                rdata_next[`B_RAIL_SRC] = rail_source_status_o;
            end
            default:
                if (is_store(sfr_addr_i))
                    rdata_next = rf[sfr_addr_i];
        endcase
    end

    // delay counters, cleared as soon as their condition drops
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            dc_cnt_reg <= 32'h0000_0000;
            main_cnt_reg <= 32'h0000_0000;
            rest_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            dc_cnt_reg <= count_step(dc_sense_low_i, dc_cnt_reg);
            main_cnt_reg <= count_step(main_low_i && mode_reg == NORMAL,
                main_cnt_reg);
            rest_cnt_reg <= count_step(restore_cond && mode_reg != NORMAL,
                rest_cnt_reg);
        end
    end

    // pin history resets to the pulled-up idle level, so reset makes no false edge
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            pin_prev_reg <= 1'b1;
        else
            pin_prev_reg <= external_switchover_pin_i;
    end

    // event flags: hardware set beats a software clear in the same cycle
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            flag_sw_reg <= 1'b0;
            flag_rest_reg <= 1'b0;
        end
        else
        begin
            if (set_sw)
                flag_sw_reg <= 1'b1;
            else if (wr_ok && sfr_addr_i == `A_EVT_FLAGS
                && !sfr_wdata_i[`B_SWITCHED])
                flag_sw_reg <= 1'b0;
            if (set_rest)
                flag_rest_reg <= 1'b1;
            else if (wr_ok && sfr_addr_i == `A_EVT_FLAGS
                && !sfr_wdata_i[`B_RESTORED])
                flag_rest_reg <= 1'b0;
        end
    end

    // register writes; blocked while the core is off in sleep
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            for (i = 0; i < 256; i = i + 1)
                rf[i] <= 8'h00;
        end
        else
        begin
            if (wr_ok && is_store(sfr_addr_i))
                rf[sfr_addr_i] <= sfr_wdata_i;
            // mode control is core-side state and is lost in sleep
            if (mode_next == SLEEP && mode_reg != SLEEP)
                rf[`A_METERING_MODE_CONTROL_ONE] <= 8'h00;
        end
    end

    // state and outputs, registered from the next mode except the warning flag, which follows the dc count
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            mode_reg <= NORMAL;
            mode_o <= NORMAL;
            rail_source_status_o <= 1'b1;
            switchover_warning_flag_o <= 1'b0;
            internal_analog_rail_en_o <= 1'b1;
            internal_logic_rail_en_o <= 1'b1;
        end
        else
        begin
            mode_reg <= mode_next;
            mode_o <= mode_next;
            rail_source_status_o <= (mode_next == NORMAL);
            switchover_warning_flag_o <= (dc_cnt_reg >= MIN_CYC);
            internal_analog_rail_en_o <= (mode_next == NORMAL);
            internal_logic_rail_en_o <= (mode_next != SLEEP);
        end
    end

    // restart pulse, and the ram validity that only a restart brings back
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ram_valid_o <= 1'b1;
            core_restart_o <= 1'b0;
            core_clk_div_o <= `CLK_DIV_DEFAULT;
        end
        else
        begin
            // ram only becomes trusted again through a restart
            if (mode_next == SLEEP)
                ram_valid_o <= 1'b0;
            else if (restart_next)
                ram_valid_o <= 1'b0;
            else if (core_restart_o)
                ram_valid_o <= 1'b1;
            core_restart_o <= restart_next;
            if (restart_next)
                core_clk_div_o <= `CLK_DIV_DEFAULT;
        end
    end

    // read data and the always-on enables seen by the peripherals
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            aon_peripheral_config_en_o <= 4'h0;
            sfr_rdata_o <= 8'h00;
        end
        else
        begin
            aon_peripheral_config_en_o <= rf[`A_PERIPHERAL_CONFIG][3:0];
            // a read in deep sleep is dropped and the last answer stands
            if (sfr_rd_i && core_on)
                sfr_rdata_o <= rdata_next;
        end
    end

endmodule // supply_switchover_mode_sequencer
`default_nettype wire

/* File: src/supply_seq_consts.vh */
// constants for the supply switchover and power mode sequencer
// assumes a 250 MHz always-on clock and an 8-bit special register port
`ifndef SUPPLY_SEQ_CONSTS_VH
`define SUPPLY_SEQ_CONSTS_VH
// clock rate and timing figures
`define CLK_MHZ 250
`define T_MIN_NS 10
`define T_MIN_CYC ((`T_MIN_NS * `CLK_MHZ + 999) / 1000)
`define T_DC_SWITCH_MS 30
`define T_DC_SWITCH_CYC (`T_DC_SWITCH_MS * `CLK_MHZ * 1000)
`define T_RESTORE_MS 130
`define T_RESTORE_CYC (`T_RESTORE_MS * `CLK_MHZ * 1000)
// register offsets
`define A_METERING_MODE_CONTROL_ONE 8'h0b
`define A_LCD_MAIN 8'h95
`define A_LCD_CLK 8'h96
`define A_LCD_SEG_A 8'h97
`define A_LCD_X 8'h9c
`define A_RTC_CFG 8'ha1
`define A_RTC_H100 8'ha2
`define A_RTC_S 8'ha3
`define A_RTC_M 8'ha4
`define A_RTC_H 8'ha5
`define A_RTC_ALARM 8'ha6
`define A_LCD_PTR 8'hac
`define A_LCD_DATA 8'hae
`define A_LCD_Y 8'hb1
`define A_PULL0 8'hb2
`define A_PULL1 8'hb3
`define A_PULL2 8'hb4
`define A_TEMP_RES 8'hd7
`define A_BAT_RES 8'hdf
`define A_LCD_SEG_B 8'hed
`define A_DC_RES 8'hef
`define A_DELTA_CFG 8'hf3
`define A_PERIPHERAL_CONFIG 8'hf4
`define A_SWO_CFG 8'hf5
`define A_RTC_TRIM 8'hf6
`define A_TEMP_TRIM 8'hf7
`define A_EVT_FLAGS 8'hf8
`define A_STRB_PER 8'hf9
`define A_BAT_TH 8'hfa
`define A_STORE1 8'hfb
`define A_STORE4 8'hfe
`define A_INT_PIN 8'hff
// field positions and values
`define B_RAIL_SRC 6
`define B_METERING_POWERDOWN_BIT 4
`define B_RESTORED 7
`define B_SWITCHED 1
`define SEL_MAIN_ONLY 2'b00
`define SEL_DC_AND_MAIN 2'b01
`define PIN_EN_CODE 2'b01
`define CLK_DIV_DEFAULT 3'h3
`define MODE_NORMAL 2'h0
`define MODE_BACKUP 2'h1
`define MODE_SLEEP 2'h2
`endif

/* File: dv/supply_seq_assertions.sv */
// port checker for the supply sequencer
// assumes one always-on clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module supply_seq_assertions #(
    parameter [31:0] DC_SWITCH_CYC = 32'h14,
    parameter [31:0] RESTORE_CYC = 32'h28
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic dc_sense_low_i,
    input wire logic main_low_i,
    input wire logic wake_event_i,
    input wire logic sleep_req_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic rail_source_status_o,
    input wire logic switchover_warning_flag_o,
    input wire logic internal_analog_rail_en_o,
    input wire logic internal_logic_rail_en_o,
    input wire logic ram_valid_o,
    input wire logic core_restart_o,
    input wire logic [1:0] mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [31:0] good_cnt;
    // healthy main run length; a lower bound only, other restore terms may add more
    always @(posedge clk_i)
        if (!rstn_i || main_low_i) good_cnt <= 32'h0;
        else good_cnt <= good_cnt + 32'h1;
    sequence dc_low_run;
        dc_sense_low_i [*6];
    endsequence
    sequence main_low_run;
        (mode_o == 2'h0 && main_low_i && !sleep_req_i) ##1
            (main_low_i && !sleep_req_i) [*2] ##1 main_low_i;
    endsequence
    sequence held(logic [1:0] m);
        mode_o == m ##1 mode_o == m;
    endsequence
    warn_not_early_a: assert property ($rose(switchover_warning_flag_o) |->
        $past(dc_sense_low_i, 2) && $past(dc_sense_low_i, 3) && $past(dc_sense_low_i, 4))
        else $error("warning too early");
    warn_raised_a: assert property (dc_low_run |-> switchover_warning_flag_o)
        else $error("warning missing");
    main_switch_a: assert property (main_low_run |-> ##[0:3] mode_o == 2'h1)
        else $error("no switchover on main low");
    normal_rails_a: assert property (held(2'h0) |-> rail_source_status_o &&
        internal_analog_rail_en_o && internal_logic_rail_en_o) else $error("normal rails");
    backup_rails_a: assert property (held(2'h1) |-> !rail_source_status_o &&
        !internal_analog_rail_en_o && internal_logic_rail_en_o) else $error("backup rails");
    sleep_rails_a: assert property (held(2'h2) |-> !rail_source_status_o &&
        !internal_logic_rail_en_o && !ram_valid_o) else $error("sleep rails");
    restart_origin_a: assert property (core_restart_o |->
        $past(mode_o, 1) == 2'h2 || $past(mode_o, 2) == 2'h2) else $error("stray restart");
    sleep_hold_a: assert property (mode_o == 2'h2 && main_low_i && !wake_event_i |=>
        mode_o == 2'h2) else $error("left sleep without wake");
    status_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'hf4 && mode_o != 2'h2 |=>
        sfr_rdata_o[6] == $past(rail_source_status_o)) else $error("status bit");
    restore_delay_a: assert property ($rose(rail_source_status_o) |->
        good_cnt >= RESTORE_CYC - 32'h2) else $error("restore too early");
endmodule // supply_seq_assertions
bind supply_switchover_mode_sequencer supply_seq_assertions #(
    .DC_SWITCH_CYC(DC_SWITCH_CYC), .RESTORE_CYC(RESTORE_CYC)) u_supply_seq_assertions (
    .clk_i(clk_i), .rstn_i(rstn_i), .dc_sense_low_i(dc_sense_low_i),
    .main_low_i(main_low_i), .wake_event_i(wake_event_i), .sfr_rd_i(sfr_rd_i),
    .sleep_req_i(sleep_req_i),
    .sfr_addr_i(sfr_addr_i), .sfr_rdata_o(sfr_rdata_o),
    .rail_source_status_o(rail_source_status_o),
    .switchover_warning_flag_o(switchover_warning_flag_o),
    .internal_analog_rail_en_o(internal_analog_rail_en_o),
    .internal_logic_rail_en_o(internal_logic_rail_en_o), .ram_valid_o(ram_valid_o),
    .core_restart_o(core_restart_o), .mode_o(mode_o));
`default_nettype wire

/* File: dv/supply_side_model.sv */
// supply unit, dc divider and battery control pin seen by the sequencer
// assumes the bench moves its requests at the falling edge, pin pulled up
`timescale 1ns/100ps
`default_nettype none
module supply_side_model (
    input wire logic clk_i,
    input wire logic main_fail_i,
    input wire logic dc_fail_i,
    input wire logic pin_pull_i,
    output logic main_low_o,
    output logic dc_sense_low_o,
    output logic pin_o
);
    initial
    begin
        main_low_o = 1'b0;
        dc_sense_low_o = 1'b0;
        pin_o = 1'b1;
    end
    // comparators follow the supply one edge later; the pin idles high through its pull-up
    // sampling on the rising edge keeps clear of the bench's falling-edge updates
    always @(posedge clk_i)
    begin
        main_low_o <= main_fail_i;
        dc_sense_low_o <= dc_fail_i;
        pin_o <= !pin_pull_i;
    end
endmodule // supply_side_model
`default_nettype wire

/* File: dv/supply_switchover_mode_sequencer_tb.sv */
// self-checking bench for the supply sequencer, short delay counts
// assumes the supply model beside it and inputs moved at the falling edge
`timescale 1ns/100ps
`default_nettype none
module supply_switchover_mode_sequencer_tb;
    logic clk_i, rstn_i, wake, sleep, wr, rd, mf, df, pf;
    logic [7:0] addr, wdata, v;
    wire logic [7:0] rdata;
    wire logic rail, warn, ana, lgc, ram, rst, mlow, dlow, pin;
    wire logic [2:0] div;
    wire logic [3:0] aon;
    wire logic [1:0] mode;
    integer fail_count, n_checks, k;
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    supply_side_model u_supply_side_model (.clk_i(clk_i), .main_fail_i(mf), .dc_fail_i(df),
        .pin_pull_i(pf), .main_low_o(mlow), .dc_sense_low_o(dlow), .pin_o(pin));
    supply_switchover_mode_sequencer #(.DC_SWITCH_CYC(32'h14), .RESTORE_CYC(32'h28))
    u_supply_switchover_mode_sequencer (.clk_i(clk_i), .rstn_i(rstn_i),
        .dc_sense_low_i(dlow), .main_low_i(mlow), .external_switchover_pin_i(pin),
        .wake_event_i(wake), .sleep_req_i(sleep), .temp_result_i(8'h3c),
        .backup_result_i(8'h71), .dc_result_i(8'h2e), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .rail_source_status_o(rail),
        .switchover_warning_flag_o(warn), .internal_analog_rail_en_o(ana),
        .internal_logic_rail_en_o(lgc), .ram_valid_o(ram), .core_restart_o(rst),
        .core_clk_div_o(div), .aon_peripheral_config_en_o(aon), .mode_o(mode));
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input [7:0] s, input [7:0] e);
        n_checks = n_checks + 1;
        if (s !== e)
        begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    // register write, strobe held for exactly one rising edge
    task wr_r(input [7:0] a, input [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
    endtask
    // read data is taken a full cycle after the strobe so it has surely settled
    task rd_r(input [7:0] a);
        @(negedge clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        @(negedge clk_i);
        v = rdata;
    endtask
    task wait_mode(input [1:0] m, input integer b);
        k = 0;
        while (mode !== m && k < b)
        begin
            @(negedge clk_i);
            k = k + 1;
        end
        if (mode !== m)
        begin
            fail_count = fail_count + 1;
            summarize;
        end
    endtask
    task t_reset;
        chk(8'(mode), 8'h00);
        chk({4'h0, rail, ana, div[1:0]}, 8'h0f);
        rd_r(8'hd7);
        chk(v, 8'h3c);
        rd_r(8'h80);
        chk(v, 8'h00);
    endtask
    task t_main;
        wr_r(8'hfc, 8'h3e);
        mf = 1'b1;
        cyc(2);
        mf = 1'b0;
        cyc(6);
        chk(8'(mode), 8'h00);
        mf = 1'b1;
        wait_mode(2'h1, 10);
        chk({4'h0, rail, ana, lgc, div[2]}, 8'h02);
        chk(8'(div), 8'h03);
        rd_r(8'hf4);
        chk(8'(v[6]), 8'h00);
        rd_r(8'hf8);
        chk(8'(v[1]), 8'h01);
        wr_r(8'hf8, 8'h00);
        rd_r(8'hf8);
        chk(8'(v[1]), 8'h00);
    endtask
    task t_restore;
        wr_r(8'h0b, 8'h10);
        mf = 1'b0;
        cyc(60);
        chk(8'(mode), 8'h01);
        wr_r(8'h0b, 8'h00);
        cyc(20);
        chk(8'(mode), 8'h01);
        wait_mode(2'h0, 40);
        chk({6'h00, rail, ana}, 8'h03);
        rd_r(8'hf8);
        chk(8'(v[7]), 8'h01);
        wr_r(8'hf8, 8'h00);
    endtask
    task t_dc;
        wr_r(8'hf5, 8'h01);
        df = 1'b1;
        cyc(1);
        chk(8'(warn), 8'h00);
        cyc(6);
        chk(8'(warn), 8'h01);
        chk(8'(mode), 8'h00);
        wait_mode(2'h1, 30);
        df = 1'b0;
        wait_mode(2'h0, 60);
        wr_r(8'hf5, 8'h00);
    endtask
    task t_pin;
        wr_r(8'hff, 8'h04);
        pf = 1'b1;
        wait_mode(2'h1, 6);
        pf = 1'b0;
        wait_mode(2'h0, 60);
        wr_r(8'hff, 8'h00);
    endtask
    task t_sleep;
        wr_r(8'hfb, 8'ha5);
        wr_r(8'hf4, 8'h05);
        cyc(1);
        chk(8'(aon), 8'h05);
        mf = 1'b1;
        @(negedge clk_i);
        sleep = 1'b1;
        @(negedge clk_i);
        sleep = 1'b0;
        wait_mode(2'h2, 4);
        cyc(50);
        chk({5'h00, lgc, ram, rail}, 8'h00);
        chk(8'(mode), 8'h02);
        chk(8'(aon), 8'h05);
        wr_r(8'hfb, 8'h00);
        wake = 1'b1;
        @(negedge clk_i);
        wake = 1'b0;
        k = 0;
        while (rst !== 1'b1 && k < 4)
        begin
            @(negedge clk_i);
            k = k + 1;
        end
        chk(8'(rst), 8'h01);
        if (rst !== 1'b1)
            summarize;
        wait_mode(2'h1, 4);
        rd_r(8'hfb);
        chk(v, 8'ha5);
        chk(8'(ram), 8'h01);
        wr_r(8'h0b, 8'h00);
        mf = 1'b0;
        wait_mode(2'h0, 60);
    endtask
    initial
    begin
        {rstn_i, wake, sleep, wr, rd, mf, df, pf} = 8'h00;
        {addr, wdata, v} = 24'h000000;
        fail_count = 0;
        n_checks = 0;
        cyc(3);
        rstn_i = 1'b1;
        cyc(1);
        t_reset;
        t_main;
        t_restore;
        t_dc;
        t_pin;
        t_sleep;
        summarize;
    end
endmodule // supply_switchover_mode_sequencer_tb
`default_nettype wire
